// ### design/pwr_cfg_pkg.sv
// Constants shared by the clock and power-good configuration bank
package pwr_cfg_pkg;

	// ****************************************************************
	// Register offsets on the serial host register port
	// ****************************************************************
	localparam logic [7:0] OFFSET_DEVICE_CONFIGURATION = 8'h13;
	localparam logic [7:0] OFFSET_CLOCK_SOURCE_CONTROL = 8'h14;
	localparam logic [7:0] OFFSET_POWER_GOOD_SETUP_ONE = 8'h15;
	localparam logic [7:0] OFFSET_POWER_GOOD_SETUP_TWO = 8'h16;

	// ****************************************************************
	// Writable bit masks; reserved bits are held at zero
	// ****************************************************************
	localparam logic [7:0] MASK_DEVICE_CONFIGURATION = 8'h7F;
	localparam logic [7:0] MASK_CLOCK_SOURCE_CONTROL = 8'h5F;
	localparam logic [7:0] MASK_POWER_GOOD_SETUP_ONE = 8'hFF;
	localparam logic [7:0] MASK_POWER_GOOD_SETUP_TWO = 8'h07;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RESET_DEVICE_CONFIGURATION = 8'h00;
	localparam logic [7:0] RESET_CLOCK_SOURCE_CONTROL = 8'h00;
	localparam logic [7:0] RESET_POWER_GOOD_SETUP_ONE = 8'h00;
	localparam logic [7:0] RESET_POWER_GOOD_SETUP_TWO = 8'h00;

	// ****************************************************************
	// Field positions: device_configuration
	// ****************************************************************
	localparam int BIT_STARTUP_RANGE     = 6;
	localparam int BIT_SHUTDOWN_RANGE    = 5;
	localparam int BIT_CLOCK_PIN_FUNC    = 4;
	localparam int BIT_CLOCK_PIN_PULL    = 3;
	localparam int BIT_ENABLE_PIN_PULL   = 2;
	localparam int BIT_THERMAL_THRESHOLD = 1;
	localparam int BIT_SPREAD_ON         = 0;

	// ****************************************************************
	// Field positions: clock_source_control
	// ****************************************************************
	localparam int BIT_PLL_ENABLE        = 6;
	localparam int BIT_RESERVED_ZERO     = 5;
	localparam int RATE_CODE_MSB         = 4;
	localparam logic [4:0] RATE_CODE_MAX = 5'h17;

	// ****************************************************************
	// Field positions: power-good setup registers
	// ****************************************************************
	localparam int BIT_PG_POLARITY       = 7;
	localparam int BIT_PG_DRIVE          = 6;
	localparam int BIT_LINEAR_WINDOW     = 5;
	localparam int BIT_SWITCHER_WINDOW   = 4;
	localparam int MONITOR_MSB           = 3;
	localparam int BIT_THERMAL_GATES     = 2;
	localparam int BIT_FAULT_GATES       = 1;
	localparam int BIT_PG_MODE           = 0;

	// Rails: 0 switcher a, 1 switcher b, 2 linear a, 3 linear b
	localparam int RAIL_COUNT            = 4;
	localparam int FIRST_LINEAR_RAIL     = 2;

	// ****************************************************************
	// Delay step timing
	// ****************************************************************
	localparam int CLOCK_PERIOD_PS       = 5000;
	localparam int STEP_FINE_US          = 500;
	localparam int STEP_COARSE_US        = 1000;
	localparam int STEP_FINE_CYCLES      =
		(STEP_FINE_US * 1000000) / CLOCK_PERIOD_PS;
	localparam int STEP_COARSE_CYCLES    =
		(STEP_COARSE_US * 1000000) / CLOCK_PERIOD_PS;
	localparam int STEP_COUNT_WIDTH      = 18;

endpackage

// ### design/pg_eval_if.sv
// Carrier between the register bank and the power-good evaluator
`timescale 1ns/1ps
interface pg_eval_if;
	import pwr_cfg_pkg::*;

	logic [RAIL_COUNT-1:0] monitor_enable;     // Rails included
	logic                  linear_window;      // Linear rails OV too
	logic                  switcher_window;    // Switcher rails OV too
	logic                  thermal_gates;      // Thermal warning gating
	logic                  fault_gates;        // Follow latched faults
	logic                  continuous_mode;    // 1 continuous, 0 gated
	logic [RAIL_COUNT-1:0] rail_undervolt;     // Live undervoltage
	logic [RAIL_COUNT-1:0] rail_overvolt;      // Live overvoltage
	logic [RAIL_COUNT-1:0] fault_latched;      // Latched per-rail faults
	logic                  thermal_warning;    // Thermal warning flag
	logic                  device_active;      // Device in active state
	logic                  rails_valid;        // Evaluated result

	modport bank
	(
		output monitor_enable, linear_window, switcher_window,
		output thermal_gates, fault_gates, continuous_mode,
		output rail_undervolt, rail_overvolt, fault_latched,
		output thermal_warning, device_active,
		input  rails_valid
	);

	modport evaluator
	(
		input  monitor_enable, linear_window, switcher_window,
		input  thermal_gates, fault_gates, continuous_mode,
		input  rail_undervolt, rail_overvolt, fault_latched,
		input  thermal_warning, device_active,
		output rails_valid
	);

endinterface

// ### design/pg_evaluator.sv
// Combines monitored rail status into one power-good verdict
`timescale 1ns/1ps
module pg_evaluator
(
	pg_eval_if.evaluator eval
);
	import pwr_cfg_pkg::*;

	// ****************************************************************
	// Per-rail window check
	// ****************************************************************
	logic [RAIL_COUNT-1:0] rail_ok;    // Rail within its thresholds
	logic [RAIL_COUNT-1:0] rail_pass;  // Rail ok or not monitored
	logic                  live_ok;    // All monitored rails ok
	logic                  latched_ok; // No monitored latched fault

	genvar r;
	generate
		for (r = 0; r < RAIL_COUNT; r++)
		begin : g_rail
			logic window_on; // Overvoltage also checked
			// Linear rails and switchers have separate window bits
			assign window_on = (r >= FIRST_LINEAR_RAIL) ?
				eval.linear_window : eval.switcher_window;
			assign rail_ok[r] = !eval.rail_undervolt[r] &&
				!(window_on && eval.rail_overvolt[r]);
			// Unmonitored rails never pull the verdict down
			assign rail_pass[r] = rail_ok[r] ||
				!eval.monitor_enable[r];
		end
	endgenerate

	// AND of every enabled source
	assign live_ok = &rail_pass;
	assign latched_ok =
		~|(eval.fault_latched & eval.monitor_enable);

	// ****************************************************************
	// Final verdict with gating
	// ****************************************************************
	always_comb
	begin
		// Latched or live source
		eval.rails_valid = eval.fault_gates ? latched_ok : live_ok;
		// Thermal warning forces inactive only when gating is on
		if (eval.thermal_gates && eval.thermal_warning)
		begin
			eval.rails_valid = 1'b0;
		end
		// Gated mode reports only while the device is active
		if (!eval.continuous_mode && !eval.device_active)
		begin
			eval.rails_valid = 1'b0;
		end
	end

endmodule

// ### design/clock_pg_config_regs.sv
// Clock source and power-good configuration register bank
//
// Functional notes
// - Startup range bit picks 0.5 or 1 ms steps
// - Shutdown range bit picks 0.5 or 1 ms steps
// - Clock pin: 0 second output, 1 clock
// - Clock pin pull-down follows its bit, both uses
// - Enable pin pull-down follows its bit
// - Spread switching on when bit is 1
// - PLL bit 0: PLL off, RC only
// - PLL bit 1: PLL runs in standby or active, external clock used when present and the pin is clock
// - External clock appear/disappear raises an event while the PLL bit is 1
// - Rate code plus one gives MHz, max 24
// - Polarity bit: 0 high valid, 1 low valid
// - Drive bit: 0 push-pull, 1 open-drain
// - Linear window bit adds overvoltage monitoring
// - Switcher window bit adds overvoltage monitoring
// - Four bits include each rail in monitoring
// - Thermal gating forces power good inactive
// - Fault gating follows latched per-rail faults
// - Mode bit: 0 gated, 1 continuous
`timescale 1ns/1ps
module clock_pg_config_regs
#(
	parameter int FINE_STEP_CYCLES   = pwr_cfg_pkg::STEP_FINE_CYCLES,
	parameter int COARSE_STEP_CYCLES = pwr_cfg_pkg::STEP_COARSE_CYCLES
)
(
	input  wire logic                  clock_in,
	input  wire logic                  rst_n_in,
	// Register port from the serial host interface
	input  wire logic [7:0]            reg_addr_in,
	input  wire logic                  reg_write_in,
	input  wire logic [7:0]            reg_wdata_in,
	output logic      [7:0]            reg_rdata_out,
	output logic                       reg_hit_out,
	// Device state
	input  wire logic                  device_standby_in,
	input  wire logic                  device_active_in,
	// Clock inputs
	input  wire logic                  external_clock_present_in,
	// Rail status
	input  wire logic [pwr_cfg_pkg::RAIL_COUNT-1:0] rail_undervolt_in,
	input  wire logic [pwr_cfg_pkg::RAIL_COUNT-1:0] rail_overvolt_in,
	input  wire logic [pwr_cfg_pkg::RAIL_COUNT-1:0] fault_latched_in,
	input  wire logic                  thermal_warning_in,
	// Delay step enables
	output logic                       startup_step_tick_out,
	output logic                       shutdown_step_tick_out,
	// Clock pin and clock source control
	output logic                       clock_pin_is_clock_out,
	output logic                       clock_pin_pulldown_out,
	output logic                       enable_pin_pulldown_out,
	output logic                       thermal_warning_threshold_out,
	output logic                       spread_switching_on_out,
	output logic                       pll_run_out,
	output logic                       use_external_clock_out,
	output logic                       clock_change_event_out,
	output logic [4:0]                 external_clock_rate_code_out,
	output logic [4:0]                 external_clock_mhz_out,
	output logic                       rate_code_reserved_out,
	// Power-good pin value and its drive enable
	output logic                       power_good_output_out,
	output logic                       power_good_output_oe_n_out
);
	import pwr_cfg_pkg::*;

	// ****************************************************************
	// Decoding helper
	// ****************************************************************

	// True when the port address selects the given register
	function automatic logic reg_sel(input logic [7:0] addr,
		input logic [7:0] offset);
		reg_sel = (addr == offset);
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0] device_configuration; // Pins, ranges, spread
	logic [7:0] clock_source_control; // PLL and rate code
	logic [7:0] power_good_setup_one; // Polarity, drive, sources
	logic [7:0] power_good_setup_two; // Gating and mode

	// Register writes; reserved bits are masked to zero so that a
	// careless write to bit 5 of the clock register cannot stick
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			device_configuration <= RESET_DEVICE_CONFIGURATION;
			clock_source_control <= RESET_CLOCK_SOURCE_CONTROL;
			power_good_setup_one <= RESET_POWER_GOOD_SETUP_ONE;
			power_good_setup_two <= RESET_POWER_GOOD_SETUP_TWO;
		end
		else if (reg_write_in)
		begin
			if (reg_sel(reg_addr_in, OFFSET_DEVICE_CONFIGURATION))
			begin
				device_configuration <=
					reg_wdata_in & MASK_DEVICE_CONFIGURATION;
			end
			if (reg_sel(reg_addr_in, OFFSET_CLOCK_SOURCE_CONTROL))
			begin
				// Bit 5 is expected as zero and kept at zero
				clock_source_control <=
					reg_wdata_in & MASK_CLOCK_SOURCE_CONTROL;
			end
			if (reg_sel(reg_addr_in, OFFSET_POWER_GOOD_SETUP_ONE))
			begin
				power_good_setup_one <=
					reg_wdata_in & MASK_POWER_GOOD_SETUP_ONE;
			end
			if (reg_sel(reg_addr_in, OFFSET_POWER_GOOD_SETUP_TWO))
			begin
				power_good_setup_two <=
					reg_wdata_in & MASK_POWER_GOOD_SETUP_TWO;
			end
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	logic [7:0] next_rdata; // Selected read value
	logic       next_hit;   // Address maps to this bank

	// Unmapped offsets read zero and report no hit
	always_comb
	begin
		next_rdata = 8'h00;
		next_hit   = 1'b1;
		if (reg_sel(reg_addr_in, OFFSET_DEVICE_CONFIGURATION))
		begin
			next_rdata = device_configuration;
		end
		else if (reg_sel(reg_addr_in, OFFSET_CLOCK_SOURCE_CONTROL))
		begin
			next_rdata = clock_source_control;
		end
		else if (reg_sel(reg_addr_in, OFFSET_POWER_GOOD_SETUP_ONE))
		begin
			next_rdata = power_good_setup_one;
		end
		else if (reg_sel(reg_addr_in, OFFSET_POWER_GOOD_SETUP_TWO))
		begin
			next_rdata = power_good_setup_two;
		end
		else
		begin
			next_hit = 1'b0;
		end
	end

	// Read data is registered, one cycle after the address
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			reg_rdata_out <= 8'h00;
			reg_hit_out   <= 1'b0;
		end
		else
		begin
			reg_rdata_out <= next_rdata;
			reg_hit_out   <= next_hit;
		end
	end

	// ****************************************************************
	// Delay step dividers
	// ****************************************************************
	localparam logic [STEP_COUNT_WIDTH-1:0] FINE_LAST =
		STEP_COUNT_WIDTH'(FINE_STEP_CYCLES - 1);
	localparam logic [STEP_COUNT_WIDTH-1:0] COARSE_LAST =
		STEP_COUNT_WIDTH'(COARSE_STEP_CYCLES - 1);

	logic [1:0] range_coarse; // 0 startup, 1 shutdown
	logic [1:0] step_tick;    // One-cycle step enables

	assign range_coarse[0] = device_configuration[BIT_STARTUP_RANGE];
	assign range_coarse[1] = device_configuration[BIT_SHUTDOWN_RANGE];

	genvar d;
	generate
		for (d = 0; d < 2; d++)
		begin : g_step
			logic [STEP_COUNT_WIDTH-1:0] count; // Cycles in step
			logic [STEP_COUNT_WIDTH-1:0] last;  // Final count
			logic                        tick;  // This divider's pulse
			// Range bit scales each delay code step
			assign last = range_coarse[d] ? COARSE_LAST : FINE_LAST;
			// Own flop per divider, so no vector has two writers
			assign step_tick[d] = tick;
			// Counter wraps at the step length; a range change
			// mid-step is clamped so no step is ever stretched
			always_ff @(posedge clock_in)
			begin
				if (!rst_n_in)
				begin
					count <= '0;
					tick  <= 1'b0;
				end
				else if (count >= last)
				begin
					count <= '0;
					tick  <= 1'b1;
				end
				else
				begin
					count <= count + 1'b1;
					tick  <= 1'b0;
				end
			end
		end
	endgenerate

	assign startup_step_tick_out  = step_tick[0];
	assign shutdown_step_tick_out = step_tick[1];

	// ****************************************************************
	// Pin and clock source control
	// ****************************************************************
	logic pll_on;        // PLL enable bit
	logic present_seen;  // Last sampled clock presence
	logic clock_usable;  // External clock may be used

	assign pll_on = clock_source_control[BIT_PLL_ENABLE];
	// Clock is only usable when the pin serves as clock input
	assign clock_usable = pll_on && external_clock_present_in &&
		device_configuration[BIT_CLOCK_PIN_FUNC];

	// Static controls straight from the registers
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			clock_pin_is_clock_out        <= 1'b0;
			clock_pin_pulldown_out        <= 1'b0;
			enable_pin_pulldown_out       <= 1'b0;
			thermal_warning_threshold_out <= 1'b0;
			spread_switching_on_out       <= 1'b0;
			external_clock_rate_code_out  <= 5'h00;
			external_clock_mhz_out        <= 5'h01;
			rate_code_reserved_out        <= 1'b0;
		end
		else
		begin
			clock_pin_is_clock_out  <=
				device_configuration[BIT_CLOCK_PIN_FUNC];
			// Pull-down applies in either pin use
			clock_pin_pulldown_out  <=
				device_configuration[BIT_CLOCK_PIN_PULL];
			enable_pin_pulldown_out <=
				device_configuration[BIT_ENABLE_PIN_PULL];
			thermal_warning_threshold_out <=
				device_configuration[BIT_THERMAL_THRESHOLD];
			spread_switching_on_out <=
				device_configuration[BIT_SPREAD_ON];
			external_clock_rate_code_out <=
				clock_source_control[RATE_CODE_MSB:0];
			// Code plus one in MHz; wraps only for reserved codes
			external_clock_mhz_out <=
				clock_source_control[RATE_CODE_MSB:0] + 5'h01;
			// Flag reserved codes rather than guess a rate
			rate_code_reserved_out <=
				clock_source_control[RATE_CODE_MSB:0] >
				RATE_CODE_MAX;
		end
	end

	// PLL and clock selection follow the enable bit and state
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			pll_run_out            <= 1'b0;
			use_external_clock_out <= 1'b0;
		end
		else
		begin
			// Bit clear: PLL off, RC only, external clock ignored
			pll_run_out <= pll_on &&
				(device_standby_in || device_active_in);
			use_external_clock_out <= clock_usable;
		end
	end

	// Presence edges become a one-cycle event, only with PLL on
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			present_seen           <= 1'b0;
			clock_change_event_out <= 1'b0;
		end
		else
		begin
			present_seen           <= external_clock_present_in;
			clock_change_event_out <= pll_on &&
				(present_seen != external_clock_present_in);
		end
	end

	// ****************************************************************
	// Power-good evaluation and pin drive
	// ****************************************************************
	pg_eval_if eval_bus ();

	assign eval_bus.monitor_enable  =
		power_good_setup_one[MONITOR_MSB:0];
	assign eval_bus.linear_window   =
		power_good_setup_one[BIT_LINEAR_WINDOW];
	assign eval_bus.switcher_window =
		power_good_setup_one[BIT_SWITCHER_WINDOW];
	assign eval_bus.thermal_gates   =
		power_good_setup_two[BIT_THERMAL_GATES];
	assign eval_bus.fault_gates     =
		power_good_setup_two[BIT_FAULT_GATES];
	assign eval_bus.continuous_mode =
		power_good_setup_two[BIT_PG_MODE];
	assign eval_bus.rail_undervolt  = rail_undervolt_in;
	assign eval_bus.rail_overvolt   = rail_overvolt_in;
	assign eval_bus.fault_latched   = fault_latched_in;
	assign eval_bus.thermal_warning = thermal_warning_in;
	assign eval_bus.device_active   = device_active_in;

	pg_evaluator u_pg_evaluator
	(
		.eval (eval_bus.evaluator)
	);

	logic pg_level; // Pin level after polarity

	// Polarity picks which level means valid
	assign pg_level = eval_bus.rails_valid ^
		power_good_setup_one[BIT_PG_POLARITY];

	// Push-pull drives both levels; open-drain only pulls low,
	// releasing the pin when the level should read high
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			power_good_output_out      <= 1'b0;
			power_good_output_oe_n_out <= 1'b1;
		end
		else if (power_good_setup_one[BIT_PG_DRIVE])
		begin
			power_good_output_out      <= 1'b0;
			power_good_output_oe_n_out <= pg_level;
		end
		else
		begin
			power_good_output_out      <= pg_level;
			power_good_output_oe_n_out <= 1'b0;
		end
	end

endmodule

// ### tb/clock_pg_config_regs_asserts.sv
// Port-level concurrent checks for the configuration bank
`timescale 1ns/1ps
module pg_regs_asserts
(
	input wire logic       clock_in,
	input wire logic       rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       device_standby_in,
	input wire logic       device_active_in,
	input wire logic       external_clock_present_in,
	input wire logic       startup_step_tick_out,
	input wire logic       shutdown_step_tick_out,
	input wire logic       clock_pin_is_clock_out,
	input wire logic       pll_run_out,
	input wire logic       use_external_clock_out,
	input wire logic       clock_change_event_out,
	input wire logic [4:0] external_clock_rate_code_out,
	input wire logic [4:0] external_clock_mhz_out,
	input wire logic       rate_code_reserved_out,
	input wire logic       power_good_output_out,
	input wire logic       power_good_output_oe_n_out
);
	// ********************************
	// One domain, reset disables all
	// ********************************
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);

	AST_RATE_PLUS_ONE: assert property (
		external_clock_mhz_out == external_clock_rate_code_out + 5'h01)
		else $error("rate MHz not code plus one");
	AST_RATE_RESERVED: assert property (
		rate_code_reserved_out == (external_clock_rate_code_out > 5'h17))
		else $error("reserved rate flag wrong");
	AST_CLK_BIT5_ZERO: assert property (
		$past(reg_addr_in) == 8'h14 |-> reg_rdata_out[5] == 1'b0)
		else $error("clock register bit 5 reads one");
	AST_PLL_NEEDS_STATE: assert property (
		pll_run_out |-> $past(device_standby_in || device_active_in))
		else $error("PLL runs outside standby or active");
	AST_EXT_NEEDS_PIN: assert property (
		use_external_clock_out |->
		clock_pin_is_clock_out && $past(external_clock_present_in))
		else $error("external clock used without pin or clock");
	// Event latency is one or two edges after the presence change
	AST_EVENT_ON_EDGE: assert property (
		clock_change_event_out |->
		$changed($past(external_clock_present_in)) ||
		$changed($past(external_clock_present_in, 2)))
		else $error("clock event without presence change");
	AST_START_TICK_GAP: assert property (
		startup_step_tick_out |=> !startup_step_tick_out [*3])
		else $error("startup ticks too close");
	AST_SHUT_TICK_GAP: assert property (
		shutdown_step_tick_out |=> !shutdown_step_tick_out [*3])
		else $error("shutdown ticks too close");
	AST_OD_LOW_ONLY: assert property (
		power_good_output_out |-> !power_good_output_oe_n_out)
		else $error("power good driven high while released");
endmodule
bind clock_pg_config_regs pg_regs_asserts chk (.clock_in, .rst_n_in,
	.reg_addr_in, .reg_rdata_out, .device_standby_in, .device_active_in,
	.external_clock_present_in, .startup_step_tick_out,
	.shutdown_step_tick_out, .clock_pin_is_clock_out, .pll_run_out,
	.use_external_clock_out, .clock_change_event_out,
	.external_clock_rate_code_out, .external_clock_mhz_out,
	.rate_code_reserved_out, .power_good_output_out,
	.power_good_output_oe_n_out);

// ### tb/test_clock_and_power_good_config_regs.sv
// Self-checking bench for the clock and power-good configuration bank
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
	$display("unexpected at %0t: got %0h want %0h", $time, a, e); end end
module test_clock_and_power_good_config_regs;
	import pwr_cfg_pkg::*;
	logic       clock_in, rst_n_in, reg_write_in, reg_hit_out;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic       standby, active, present, twarn;  // Device state inputs
	logic [3:0] uv, ov, flt;                      // Rail status inputs
	logic       st_tick, sh_tick, pin_clk, pin_pd, enable_pin_pulldown, thr, spread;
	logic       pll_run, use_ext, ev, rsv, pg_out, pg_oen;
	logic [4:0] code, mhz;
	int         fails, check_count, n;

	// Short step counts keep tick periods measurable
	clock_pg_config_regs #(.FINE_STEP_CYCLES(4), .COARSE_STEP_CYCLES(8)) dut
	(
		.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
		.reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .reg_hit_out(reg_hit_out),
		.device_standby_in(standby), .device_active_in(active),
		.external_clock_present_in(present), .rail_undervolt_in(uv),
		.rail_overvolt_in(ov), .fault_latched_in(flt),
		.thermal_warning_in(twarn), .startup_step_tick_out(st_tick),
		.shutdown_step_tick_out(sh_tick), .clock_pin_is_clock_out(pin_clk),
		.clock_pin_pulldown_out(pin_pd), .enable_pin_pulldown_out(enable_pin_pulldown),
		.thermal_warning_threshold_out(thr),
		.spread_switching_on_out(spread), .pll_run_out(pll_run),
		.use_external_clock_out(use_ext), .clock_change_event_out(ev),
		.external_clock_rate_code_out(code), .external_clock_mhz_out(mhz),
		.rate_code_reserved_out(rsv), .power_good_output_out(pg_out),
		.power_good_output_oe_n_out(pg_oen)
	);

	// ********************************
	// Bus and settle helpers
	// ********************************
	// Two edges cover both the write edge and the output edge
	task automatic settle();
		repeat (2) @(posedge clock_in);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_write_in <= 1'b1;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock_in);
		reg_addr_in <= a;
		settle();
		`CHK(reg_rdata_out, e)
	endtask
	// Applies rail inputs, then checks the pin value and its enable
	task automatic pg(input logic [3:0] u, o, f, input logic t, a, eo, en);
		@(posedge clock_in);
		uv <= u;
		ov <= o;
		flt <= f;
		twarn <= t;
		active <= a;
		settle();
		`CHK(pg_out, eo)
		`CHK(pg_oen, en)
	endtask
	// Counts event pulses after one presence toggle
	task automatic toggle_clock(output int k);
		@(posedge clock_in);
		present <= !present;
		k = 0;
		repeat (4)
		begin
			@(posedge clock_in);
			#1;
			k += int'(ev === 1'b1);
		end
	endtask
	// Cycles between the second and third tick seen
	task automatic tick_gap(input logic shut, output int k);
		int seen;
		seen = 0;
		k = 0;
		while (seen < 3 && k < 60)
		begin
			@(posedge clock_in);
			#1;
			k++;
			if ((shut ? sh_tick : st_tick) === 1'b1)
			begin
				seen++;
				if (seen < 3)
					k = 0;
			end
		end
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_reset_and_pins();
		rd_chk(8'h13, 8'h00);
		rd_chk(8'h14, 8'h00);
		rd_chk(8'h15, 8'h00);
		rd_chk(8'h16, 8'h00);
		rd_chk(8'h17, 8'h00);
		`CHK(reg_hit_out, 1'b0)
		wr(8'h13, 8'hFF);
		rd_chk(8'h13, 8'h7F);
		`CHK(reg_hit_out, 1'b1)
		`CHK(pin_clk, 1'b1)
		`CHK(enable_pin_pulldown, 1'b1)
		`CHK(spread, 1'b1)
		`CHK(thr, 1'b1)
		wr(8'h13, 8'h08);
		settle();
		`CHK(pin_clk, 1'b0)
		`CHK(pin_pd, 1'b1)
		`CHK(enable_pin_pulldown, 1'b0)
		`CHK(spread, 1'b0)
		`CHK(thr, 1'b0)
		$display("test reset and pins finished");
	endtask
	task automatic t_clock_source();
		wr(8'h13, 8'h10);
		// Bit 5 written as zero, rate code kept out of reserved range
		wr(8'h14, 8'hC0);
		rd_chk(8'h14, 8'h40);
		`CHK(rsv, 1'b0)
		`CHK(code, 5'h00)
		`CHK(mhz, 5'h01)
		`CHK(pin_pd, 1'b0)
		wr(8'h14, 8'h57);
		settle();
		`CHK(code, 5'h17)
		`CHK(mhz, 5'h18)
		`CHK(rsv, 1'b0)
		toggle_clock(n);
		`CHK(n, 1)
		`CHK(use_ext, 1'b1)
		`CHK(pll_run, 1'b1)
		toggle_clock(n);
		`CHK(n, 1)
		@(posedge clock_in);
		standby <= 1'b0;
		settle();
		`CHK(pll_run, 1'b0)
		@(posedge clock_in);
		standby <= 1'b1;
		wr(8'h14, 8'h17);
		toggle_clock(n);
		`CHK(n, 0)
		`CHK(use_ext, 1'b0)
		`CHK(pll_run, 1'b0)
		$display("test clock source finished");
	endtask
	task automatic t_power_good();
		wr(8'h16, 8'h01);
		wr(8'h15, 8'h0F);
		pg(4'h0, 4'h0, 4'h0, 0, 1, 1, 0);
		pg(4'h4, 4'h0, 4'h0, 0, 1, 0, 0);
		wr(8'h15, 8'h0B);
		pg(4'h4, 4'h1, 4'h0, 0, 1, 1, 0);
		wr(8'h15, 8'h1B);
		pg(4'h4, 4'h1, 4'h0, 0, 1, 0, 0);
		wr(8'h15, 8'h2B);
		pg(4'h4, 4'h8, 4'h0, 0, 1, 0, 0);
		wr(8'h15, 8'hCB);
		pg(4'h4, 4'h0, 4'h0, 0, 1, 0, 0);
		wr(8'h15, 8'h4B);
		pg(4'h4, 4'h0, 4'h0, 0, 1, 0, 1);
		wr(8'h15, 8'h0B);
		pg(4'h0, 4'h8, 4'h0, 1, 1, 1, 0);
		wr(8'h16, 8'h05);
		pg(4'h0, 4'h0, 4'h0, 1, 1, 0, 0);
		wr(8'h16, 8'h03);
		pg(4'h1, 4'h0, 4'h0, 0, 1, 1, 0);
		pg(4'h0, 4'h0, 4'h1, 0, 1, 0, 0);
		wr(8'h16, 8'h00);
		pg(4'h0, 4'h0, 4'h0, 0, 0, 0, 0);
		wr(8'h16, 8'h01);
		pg(4'h0, 4'h0, 4'h0, 0, 0, 1, 0);
		$display("test power good finished");
	endtask
	task automatic t_step_ticks();
		wr(8'h13, 8'h00);
		tick_gap(0, n);
		`CHK(n, 4)
		tick_gap(1, n);
		`CHK(n, 4)
		wr(8'h13, 8'h60);
		tick_gap(0, n);
		`CHK(n, 8)
		tick_gap(1, n);
		`CHK(n, 8)
		$display("test step ticks finished");
	endtask

	// ********************************
	// Verdict, clock, watchdog, main
	// ********************************
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	// Tests need well under 2000 cycles; 200 us is a wide margin
	initial
	begin
		#200000;
		fails++;
		close_out();
	end
	initial
	begin
		{rst_n_in, reg_write_in, standby, active, present, twarn} = '0;
		{reg_addr_in, reg_wdata_in, uv, ov, flt} = '0;
		fails = 0;
		check_count = 0;
		repeat (6) @(posedge clock_in);
		rst_n_in <= 1'b1;
		standby <= 1'b1;
		t_reset_and_pins();
		t_clock_source();
		t_power_good();
		t_step_ticks();
		close_out();
	end
endmodule
